// ### inc/tam_defines.vh
`ifndef TAM_DEFINES_VH
`define TAM_DEFINES_VH

// ------------------------------------------------------------
// Management register addresses
// ------------------------------------------------------------
`define TAM_REG_CTRL        5'h00
`define TAM_REG_STAT        5'h01
`define TAM_REG_RSV2        5'h02
`define TAM_REG_RSV3        5'h03
`define TAM_REG_ADV         5'h04
`define TAM_REG_LPB         5'h05
`define TAM_REG_EXP         5'h06
`define TAM_REG_NPTX        5'h07
`define TAM_REG_LPNP        5'h08

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define TAM_CTRL_RST        15
`define TAM_CTRL_LOOP       14
`define TAM_CTRL_ANEN       12
`define TAM_CTRL_RESTART    9

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define TAM_STAT_EXT        8
`define TAM_STAT_PRE_SUP    6
`define TAM_STAT_AN_DONE    5
`define TAM_STAT_RFAULT     4
`define TAM_STAT_AN_ABLE    3
`define TAM_STAT_LINK       2
`define TAM_STAT_EXT_CAP    0

// ------------------------------------------------------------
// Advertisement and partner fields
// ------------------------------------------------------------
`define TAM_ADV_NP          15
`define TAM_ADV_RF_HI       13
`define TAM_ADV_RF_LO       12
`define TAM_ADV_BASE_B11    11
`define TAM_ADV_ASM         8
`define TAM_ADV_SYM         7
`define TAM_ADV_HALF        6
`define TAM_ADV_FULL        5
`define TAM_ADV_X_WMASK     16'hB1E0
`define TAM_ADV_T_WMASK     16'hBFFF
`define TAM_LPB_X_RMASK     16'hF1E0
`define TAM_LPB_T_WMASK     16'h03FF
`define TAM_NPTX_X_WMASK    16'hB7FF
`define TAM_NPTX_TOGGLE     11
`define TAM_EXP_NP_ABLE     2
`define TAM_EXP_PAGE_RX     1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TAM_ADV_RESET       16'h0000
`define TAM_NPTX_RESET      16'h0000
`define TAM_LP_RESET        16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TAM_CLK_NS          100
`define TAM_RST_HOLD_NS     400
`define TAM_RST_CYCLES      ((`TAM_RST_HOLD_NS + `TAM_CLK_NS - 1) / `TAM_CLK_NS)

`endif

// ### sim/tam_regs_assertions.sv
`timescale 1ns/10ps
module tam_regs_chk (
    input wire        i_clk,
    input wire        i_rstn,
    input wire        i_mode_1000x,
    input wire [9:0]  i_tx_cg,
    input wire [9:0]  i_rx_cg,
    input wire [9:0]  o_rx_cg,
    input wire        o_tx_reset,
    input wire        o_rx_reset,
    input wire        o_an_reset,
    input wire        o_an_enable,
    input wire        o_an_restart,
    input wire [15:0] o_adv_word,
    input wire        i_page_stb,
    input wire        i_page_next,
    input wire [15:0] i_page_word,
    input wire [2:0]  o_loc_pause,
    input wire [1:0]  o_loc_fault,
    input wire [2:0]  o_lp_pause,
    input wire [1:0]  o_lp_fault,
    input wire        o_lp_np,
    input wire        o_lp_half,
    input wire        o_lp_full
);
    reg [15:0] page_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // Held copy lets the partner decode be judged after its latency
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn)
            page_q <= 16'h0000;
        else if (i_page_stb)
            page_q <= i_page_word;
    end

    function automatic [2:0] pdec(input [1:0] c, input [2:0] both);
        pdec = (c == 2'b01) ? 3'b010 : (c == 2'b10) ? 3'b001 : (c == 2'b11) ? both : 3'b000;
    endfunction

    sequence s_rst_hold;
        o_tx_reset [*4] ##1 !o_tx_reset;
    endsequence

    sequence s_base_page;
        i_page_stb && !i_page_next && i_mode_1000x;
    endsequence

    a_rst_hold: assert property ($rose(o_tx_reset) |-> s_rst_hold)
        else $error("reset pulse length wrong");
    a_rst_same: assert property (o_tx_reset == o_rx_reset && o_rx_reset == o_an_reset)
        else $error("sub-module resets differ");
    a_loop_path: assert property ($past(i_rstn) |->
        (o_rx_cg == $past(i_tx_cg) || o_rx_cg == $past(i_rx_cg)))
        else $error("receive code group from wrong source");
    a_restart_en: assert property (o_an_restart |-> o_an_enable)
        else $error("restart while disabled");
    a_restart_one: assert property (o_an_restart |=> !o_an_restart)
        else $error("restart longer than one cycle");
    a_lp_duplex: assert property (s_base_page |-> ##3
        (o_lp_half == page_q[6] && o_lp_full == page_q[5] && o_lp_np == page_q[15]))
        else $error("partner duplex bits wrong");
    a_lp_fault: assert property (s_base_page |-> ##3 o_lp_fault == page_q[13:12])
        else $error("partner fault code wrong");
    a_lp_pause: assert property (s_base_page |-> ##3
        o_lp_pause == pdec(page_q[8:7], 3'b110))
        else $error("partner pause decode wrong");
    a_loc_code: assert property (i_mode_1000x && $past(i_mode_1000x, 3) |->
        o_loc_pause == pdec(o_adv_word[8:7], 3'b100) && o_loc_fault == o_adv_word[13:12])
        else $error("local pause or fault decode wrong");
endmodule

bind tam_regs tam_regs_chk tam_regs_chk_i (.i_clk, .i_rstn, .i_mode_1000x, .i_tx_cg, .i_rx_cg,
    .o_rx_cg, .o_tx_reset, .o_rx_reset, .o_an_reset, .o_an_enable, .o_an_restart, .o_adv_word,
    .i_page_stb, .i_page_next, .i_page_word, .o_loc_pause, .o_loc_fault, .o_lp_pause,
    .o_lp_fault, .o_lp_np, .o_lp_half, .o_lp_full);

// ### sim/tam_station.sv
`timescale 1ns/10ps
module tam_station (
    input  wire i_clk,
    input  wire i_mdio,
    output reg  o_mdc,
    output reg  o_mdio,
    output reg  o_mdio_oe
);
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end

    task automatic half_bit;
        repeat (4) @(posedge i_clk);
    endtask

    // Clock stands low between frames; a released line rests on its pull-up
    task automatic frame(input rd, input [4:0] ra, input [15:0] wd, output [15:0] rdd);
        reg [31:0] bits;
        integer    n;
        bits = {2'b01, rd, !rd, 5'h00, ra, 2'b10, wd};
        rdd = 16'h0000;
        for (n = 31; n >= 0; n = n - 1) begin
            o_mdio_oe <= !(rd && n < 18);
            o_mdio <= bits[n];
            half_bit;
            o_mdc <= 1'b1;
            if (n < 16)
                rdd[n] = i_mdio;
            half_bit;
            o_mdc <= 1'b0;
        end
        o_mdio_oe <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

// ### sim/test_tam_regs.sv
`timescale 1ns/10ps
module test_tam_regs;
    localparam [11:0] LOC = 12'h850;
    localparam [11:0] LP  = 12'hC50;
    reg          i_clk;
    reg          i_rstn;
    reg          i_mode_1000x;
    reg   [9:0]  i_tx_cg;
    reg   [9:0]  i_rx_cg;
    reg          i_np_sent;
    reg          i_page_stb;
    reg          i_page_next;
    reg   [15:0] i_page_word;
    reg          i_an_complete;
    reg          i_link_ok;
    reg          i_remote_fault;
    wire         mdc;
    wire         st_mdio;
    wire         st_oe;
    wire         dut_mdio;
    wire         dut_oe;
    wire         mdio_w;
    wire  [9:0]  o_rx_cg;
    wire         o_tx_reset;
    wire         o_an_restart;
    wire  [15:0] o_np_word;
    wire  [2:0]  o_loc_pause;
    wire  [2:0]  o_lp_pause;
    wire  [1:0]  o_loc_fault;
    wire  [1:0]  o_lp_fault;
    wire         o_lp_np;
    wire         o_lp_half;
    wire         o_lp_full;
    integer      fails;
    integer      checks;
    integer      restarts;
    integer      rst_len;
    reg   [15:0] rd;

    // Pull-up holds the shared line high when nobody drives it
    assign mdio_w = dut_oe ? dut_mdio : (st_oe ? st_mdio : 1'b1);

    tam_regs tam_regs_i (.i_clk, .i_rstn, .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(dut_mdio),
        .o_mdio_oe(dut_oe), .i_mode_1000x, .i_tx_cg, .i_rx_cg, .o_rx_cg, .o_tx_reset,
        .o_rx_reset(), .o_an_reset(), .o_an_enable(), .o_an_restart, .o_adv_word(),
        .o_np_word, .i_np_sent, .i_page_stb, .i_page_next, .i_page_word, .i_an_complete,
        .i_link_ok, .i_remote_fault, .o_loc_pause, .o_loc_fault, .o_lp_pause, .o_lp_fault,
        .o_lp_np, .o_lp_half, .o_lp_full);
    tam_station tam_station_i (.i_clk, .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(st_mdio),
        .o_mdio_oe(st_oe));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (o_an_restart === 1'b1)
            restarts <= restarts + 1;
        if (o_tx_reset === 1'b1)
            rst_len <= rst_len + 1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input [15:0] seen, input [15:0] exp, input string what);
        checks = checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input [4:0] a, input [15:0] d);
        reg [15:0] x;
        tam_station_i.frame(1'b0, a, d, x);
    endtask

    task automatic rdreg(input [4:0] a, input [15:0] exp, input string what);
        tam_station_i.frame(1'b1, a, 16'h0000, rd);
        check(rd, exp, what);
    endtask

    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults;
        rdreg(5'h00, 16'h0000, "control");
        rdreg(5'h01, 16'h0149, "status");
        rdreg(5'h06, 16'h0004, "expansion");
        wr(5'h03, 16'hFFFF);
        rdreg(5'h03, 16'h0000, "reserved");
        $display("t_defaults done");
    endtask

    task automatic t_status;
        i_an_complete <= 1'b1;
        i_link_ok <= 1'b1;
        i_remote_fault <= 1'b1;
        rdreg(5'h01, 16'h015D, "status off");
        wr(5'h00, 16'h1000);
        rdreg(5'h01, 16'h017D, "status on");
        i_link_ok <= 1'b0;
        i_remote_fault <= 1'b0;
        rdreg(5'h01, 16'h0169, "status down");
        $display("t_status done");
    endtask

    task automatic t_control;
        restarts = 0;
        wr(5'h00, 16'h1200);
        check(restarts[15:0], 16'h0001, "restart");
        rdreg(5'h00, 16'h1000, "control");
        wr(5'h04, 16'h1000);
        check(restarts[15:0], 16'h0002, "fault restart");
        wr(5'h00, 16'h0200);
        rdreg(5'h00, 16'h0000, "control");
        check(restarts[15:0], 16'h0002, "no restart");
        rst_len = 0;
        wr(5'h00, 16'h8000);
        check(rst_len[15:0], 16'h0004, "reset length");
        rdreg(5'h00, 16'h0000, "control");
        $display("t_control done");
    endtask

    task automatic t_loopback;
        i_tx_cg <= 10'h2AA;
        i_rx_cg <= 10'h155;
        wr(5'h00, 16'h4000);
        check({6'h00, o_rx_cg}, 16'h02AA, "loop on");
        wr(5'h00, 16'h0000);
        check({6'h00, o_rx_cg}, 16'h0155, "loop off");
        $display("t_loopback done");
    endtask

    task automatic t_pause;
        integer    i;
        reg [1:0]  c;
        reg [15:0] w;
        for (i = 0; i < 4; i = i + 1) begin
            c = i[1:0];
            w = {2'b00, c, 3'b000, c, 2'b11, 5'h00};
            wr(5'h04, w);
            rdreg(5'h04, w, "advert");
            check({11'h000, o_loc_fault, o_loc_pause}, {11'h000, c, LOC[3*c +: 3]}, "loc");
            w = {2'b10, c, 3'b000, c, c, 5'h00};
            i_page_word <= w;
            i_page_stb <= 1'b1;
            @(posedge i_clk);
            i_page_stb <= 1'b0;
            rdreg(5'h05, w, "partner");
            check({8'h00, o_lp_np, o_lp_half, o_lp_full, o_lp_fault, o_lp_pause},
                {8'h00, 1'b1, c, c, LP[3*c +: 3]}, "partner bits");
            rdreg(5'h06, 16'h0006, "page seen");
            rdreg(5'h06, 16'h0004, "page clear");
        end
        $display("t_pause done");
    endtask

    task automatic t_toggle;
        wr(5'h00, 16'h1000);
        wr(5'h07, 16'hFFFF);
        rdreg(5'h07, 16'hBFFF, "next page");
        i_np_sent <= 1'b1;
        @(posedge i_clk);
        i_np_sent <= 1'b0;
        rdreg(5'h07, 16'hB7FF, "toggle");
        check(o_np_word, 16'hB7FF, "page word");
        wr(5'h07, 16'h2001);
        rdreg(5'h07, 16'h2001, "null page");
        $display("t_toggle done");
    endtask

    task automatic t_tenbit;
        i_mode_1000x <= 1'b0;
        wr(5'h07, 16'h5A5A);
        rdreg(5'h07, 16'h5A5A, "storage");
        wr(5'h04, 16'hFFFF);
        rdreg(5'h04, 16'hBFFF, "ten-bit adv");
        wr(5'h04, 16'h0001);
        rdreg(5'h04, 16'h0001, "fixed adv");
        i_page_word <= 16'hD800;
        i_page_stb <= 1'b1;
        @(posedge i_clk);
        i_page_stb <= 1'b0;
        rdreg(5'h05, 16'hD800, "ten-bit partner");
        $display("t_tenbit done");
    endtask

    initial begin
        #3000000;
        fails = fails + 1;
        complete_run;
    end

    initial begin
        fails = 0;
        checks = 0;
        restarts = 0;
        rst_len = 0;
        i_rstn = 1'b0;
        i_mode_1000x = 1'b1;
        i_tx_cg = 10'h000;
        i_rx_cg = 10'h000;
        i_np_sent = 1'b0;
        i_page_stb = 1'b0;
        i_page_next = 1'b0;
        i_page_word = 16'h0000;
        i_an_complete = 1'b0;
        i_link_ok = 1'b0;
        i_remote_fault = 1'b0;
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_defaults;
        t_status;
        t_control;
        t_loopback;
        t_pause;
        t_toggle;
        t_tenbit;
        complete_run;
    end
endmodule

// ### src/tam_mdio_slave.v
`timescale 1ns/10ps
module tam_mdio_slave #(
    parameter [4:0] PHY_ADDR = 5'h00
) (
    input  wire        i_clk,
    input  wire        i_rstn,
    input  wire        i_mdc,
    input  wire        i_mdio,
    input  wire [15:0] i_rdata,
    output reg  [4:0]  o_addr,
    output reg         o_rd_stb,
    output reg         o_wr_stb,
    output reg  [15:0] o_wdata,
    output reg         o_mdio,
    output reg         o_mdio_oe
);

// ------------------------------------------------------------
// Frame states
// ------------------------------------------------------------
localparam [3:0] S_IDLE = 4'h1;
localparam [3:0] S_HDR  = 4'h2;
localparam [3:0] S_TA   = 4'h4;
localparam [3:0] S_DATA = 4'h8;

reg  [1:0]  mdc_s_q;
reg  [1:0]  mdio_s_q;
reg         mdc_d_q;
reg  [3:0]  st_q;
reg  [4:0]  cnt_q;
reg  [13:0] hdr_q;
reg  [15:0] sh_q;
reg         rd_q;
reg         hit_q;

wire        rise  = mdc_s_q[1] & ~mdc_d_q;
wire        bit_i = mdio_s_q[1];
wire [13:0] hdr_n = {hdr_q[12:0], bit_i};

// Preamble is optional: any zero seen in idle opens a frame
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        mdc_s_q   <= 2'h0;
        mdio_s_q  <= 2'h3;
        mdc_d_q   <= 1'b0;
        st_q      <= S_IDLE;
        cnt_q     <= 5'h00;
        hdr_q     <= 14'h0000;
        sh_q      <= 16'h0000;
        rd_q      <= 1'b0;
        hit_q     <= 1'b0;
        o_addr    <= 5'h00;
        o_rd_stb  <= 1'b0;
        o_wr_stb  <= 1'b0;
        o_wdata   <= 16'h0000;
        o_mdio    <= 1'b0;
        o_mdio_oe <= 1'b0;
    end else begin
        mdc_s_q  <= {mdc_s_q[0], i_mdc};
        mdio_s_q <= {mdio_s_q[0], i_mdio};
        mdc_d_q  <= mdc_s_q[1];
        o_rd_stb <= 1'b0;
        o_wr_stb <= 1'b0;
        if (rise) begin
            case (st_q)
                S_IDLE: begin
                    if (!bit_i) begin
                        hdr_q <= 14'h0000;
                        cnt_q <= 5'h01;
                        st_q  <= S_HDR;
                    end
                end
                S_HDR: begin
                    hdr_q <= hdr_n;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h0D) begin
                        cnt_q <= 5'h00;
                        if (hdr_n[13:12] != 2'b01 || hdr_n[11:10] == 2'b00 ||
                            hdr_n[11:10] == 2'b11) begin
                            st_q <= S_IDLE;
                        end else begin
                            hit_q    <= (hdr_n[9:5] == PHY_ADDR);
                            rd_q     <= (hdr_n[11:10] == 2'b10);
                            o_addr   <= hdr_n[4:0];
                            o_rd_stb <= (hdr_n[9:5] == PHY_ADDR) && (hdr_n[11:10] == 2'b10);
                            st_q     <= S_TA;
                        end
                    end
                end
                S_TA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h00 && rd_q && hit_q) begin
                        o_mdio_oe <= 1'b1;
                        o_mdio    <= 1'b0;
                    end
                    if (cnt_q == 5'h01) begin
                        cnt_q  <= 5'h00;
                        st_q   <= S_DATA;
                        o_mdio <= rd_q & hit_q & i_rdata[15];
                        sh_q   <= {i_rdata[14:0], 1'b0};
                    end
                end
                S_DATA: begin
                    cnt_q  <= cnt_q + 5'h01;
                    sh_q   <= {sh_q[14:0], bit_i};
                    o_mdio <= rd_q & hit_q & sh_q[15];
                    if (cnt_q == 5'h0F) begin
                        st_q      <= S_IDLE;
                        o_mdio_oe <= 1'b0;
                        o_mdio    <= 1'b0;
                        o_wdata   <= {sh_q[14:0], bit_i};
                        o_wr_stb  <= hit_q & ~rd_q;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
end

endmodule

// ### src/tam_regs.v
// Overview of operation
// - Reset bit pulses sub-module resets, self-clears
// - Loopback routes transmit code-groups into receive
// - Enable starts negotiation, else registers decide
// - Restart only when enabled, then self-clears
// - Status constant capability bits read one
// - Complete reads one only when negotiation finished
// - Remote fault status follows detected fault
// - Link status reads one only with link
// - Addresses four, five, seven and eight follow mode
// - Local remote fault code, nonzero renegotiates outside ten-bit mode
// - Local pause two-bit encoding
// - Writable half and full duplex advertisement
// - Ten-bit partner link, ack, duplex, speed
// - Partner next-page and fault code read-only
// - Partner pause code three means both
// - Partner duplex bits reflect partner ability
// - Expansion next-page-able always reads one
// - Page received latches, clears on read
// - Next-page transmit writable flags and code
// - Toggle inverts per page, starts inverted
// - Ten-bit mode next-page register is storage
`timescale 1ns/10ps
`include "tam_defines.vh"
module tam_regs #(
    parameter [4:0] PHY_ADDR = 5'h00
) (
    input  wire        i_clk,
    input  wire        i_rstn,
    input  wire        i_mdc,
    input  wire        i_mdio,
    output wire        o_mdio,
    output wire        o_mdio_oe,
    input  wire        i_mode_1000x,
    input  wire [9:0]  i_tx_cg,
    input  wire [9:0]  i_rx_cg,
    output reg  [9:0]  o_rx_cg,
    output wire        o_tx_reset,
    output wire        o_rx_reset,
    output wire        o_an_reset,
    output wire        o_an_enable,
    output reg         o_an_restart,
    output wire [15:0] o_adv_word,
    output wire [15:0] o_np_word,
    input  wire        i_np_sent,
    input  wire        i_page_stb,
    input  wire        i_page_next,
    input  wire [15:0] i_page_word,
    input  wire        i_an_complete,
    input  wire        i_link_ok,
    input  wire        i_remote_fault,
    output wire [2:0]  o_loc_pause,
    output wire [1:0]  o_loc_fault,
    output wire [2:0]  o_lp_pause,
    output wire [1:0]  o_lp_fault,
    output wire        o_lp_np,
    output wire        o_lp_half,
    output wire        o_lp_full
);

// ------------------------------------------------------------
// Pause decode: {asym toward local, symmetric, asym toward partner}
// ------------------------------------------------------------
function [2:0] pause_dec;
    input sym;
    input asm;
    input partner;
    begin
        case ({sym, asm})
            2'b01:   pause_dec = 3'h1;
            2'b10:   pause_dec = 3'h2;
            // Partner's code 3 means both symmetric and asym toward us
            2'b11:   pause_dec = partner ? 3'h6 : 3'h4;
            default: pause_dec = 3'h0;
        endcase
    end
endfunction

// ------------------------------------------------------------
// Serial management access
// ------------------------------------------------------------
wire [4:0]  addr;
wire        rd_stb;
wire        wr_stb;
wire [15:0] wdata;
reg  [15:0] rdata_q;
reg  [15:0] rd_mux;

tam_mdio_slave #(
    .PHY_ADDR  (PHY_ADDR)
) u_mdio (
    .i_clk     (i_clk),
    .i_rstn    (i_rstn),
    .i_mdc     (i_mdc),
    .i_mdio    (i_mdio),
    .i_rdata   (rdata_q),
    .o_addr    (addr),
    .o_rd_stb  (rd_stb),
    .o_wr_stb  (wr_stb),
    .o_wdata   (wdata),
    .o_mdio    (o_mdio),
    .o_mdio_oe (o_mdio_oe)
);

// ------------------------------------------------------------
// State
// ------------------------------------------------------------
reg  [1:0]  mode_s_q;
reg         loop_q;
reg         an_en_q;
reg         rst_q;
reg  [3:0]  rst_cnt_q;
reg  [15:0] adv_q;
reg  [15:0] nptx_q;
reg  [15:0] lpb_q;
reg  [15:0] lpnp_q;
reg         page_rx_q;
reg         tog_q;
reg         restart_pend_q;

localparam [31:0] RST_CYCLES = `TAM_RST_CYCLES;

// Mode pin is a strap from outside; synchronised before use
wire        x_mode   = mode_s_q[1];
wire        wr_ctrl  = wr_stb && (addr == `TAM_REG_CTRL);
wire        wr_adv   = wr_stb && (addr == `TAM_REG_ADV);
wire        rd_exp   = rd_stb && (addr == `TAM_REG_EXP);
wire [15:0] adv_mask = x_mode ? `TAM_ADV_X_WMASK : `TAM_ADV_T_WMASK;
wire [15:0] adv_new  = wdata & adv_mask;
wire        fault_rn = x_mode && wr_adv &&
                       (adv_new[`TAM_ADV_RF_HI:`TAM_ADV_RF_LO] != 2'b00);
wire        ctrl_en  = wr_ctrl ? wdata[`TAM_CTRL_ANEN] : an_en_q;
// restart honoured only with negotiation enabled
wire        restart  = ctrl_en && ((wr_ctrl && wdata[`TAM_CTRL_RESTART]) || fault_rn);

always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        mode_s_q <= 2'h0;
    end else begin
        mode_s_q <= {mode_s_q[0], i_mode_1000x};
    end
end

// ------------------------------------------------------------
// Control register
// ------------------------------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        loop_q       <= 1'b0;
        an_en_q      <= 1'b0;
        rst_q        <= 1'b0;
        rst_cnt_q    <= 4'h0;
        o_an_restart <= 1'b0;
    end else begin
        o_an_restart <= restart;
        if (wr_ctrl) begin
            loop_q  <= wdata[`TAM_CTRL_LOOP];
            an_en_q <= wdata[`TAM_CTRL_ANEN];
        end
        // held for a fixed time, then self-clears
        if (wr_ctrl && wdata[`TAM_CTRL_RST]) begin
            rst_q     <= 1'b1;
            rst_cnt_q <= RST_CYCLES[3:0];
        end else if (rst_cnt_q != 4'h0) begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
            rst_q     <= (rst_cnt_q != 4'h1);
        end
    end
end

assign o_tx_reset  = rst_q;
assign o_rx_reset  = rst_q;
assign o_an_reset  = rst_q;
// zero means the advertised values fix the link
assign o_an_enable = an_en_q;

// loopback mux, no clock switching here
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        o_rx_cg <= 10'h000;
    end else begin
        o_rx_cg <= loop_q ? i_tx_cg : i_rx_cg;
    end
end

// ------------------------------------------------------------
// Advertisement, next page and partner registers
// ------------------------------------------------------------
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        adv_q  <= `TAM_ADV_RESET;
        nptx_q <= `TAM_NPTX_RESET;
        lpb_q  <= `TAM_LP_RESET;
        lpnp_q <= `TAM_LP_RESET;
    end else begin
        // write masks follow the selected mode
        // ten-bit mode leaves the fixed pattern to software
        if (wr_adv) begin
            adv_q <= adv_new;
        end
        if (wr_stb && addr == `TAM_REG_NPTX) begin
            // ten-bit mode keeps all sixteen bits
            nptx_q <= x_mode ? (wdata & `TAM_NPTX_X_WMASK) : wdata;
        end
        // ten-bit partner low field is writable storage
        if (wr_stb && addr == `TAM_REG_LPB && !x_mode) begin
            lpb_q <= (lpb_q & ~`TAM_LPB_T_WMASK) | (wdata & `TAM_LPB_T_WMASK);
        end else if (i_page_stb && !i_page_next) begin
            lpb_q <= i_page_word;
        end
        if (wr_stb && addr == `TAM_REG_LPNP && !x_mode) begin
            lpnp_q <= wdata;
        end else if (i_page_stb && i_page_next && x_mode) begin
            lpnp_q <= i_page_word;
        end
    end
end

// page received latch, a new page beats the read clear
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        page_rx_q <= 1'b0;
    end else if (i_page_stb) begin
        page_rx_q <= 1'b1;
    end else if (rd_exp || rst_q) begin
        page_rx_q <= 1'b0;
    end
end

// toggle restarts opposite base bit 11, flips per sent page
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        tog_q <= 1'b1;
    end else if (restart || rst_q || !an_en_q) begin
        tog_q <= ~adv_q[`TAM_ADV_BASE_B11];
    end else if (i_np_sent) begin
        tog_q <= ~tog_q;
    end
end

// completion hidden until a restart has been seen by the engine
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        restart_pend_q <= 1'b0;
    end else if (restart || rst_q) begin
        restart_pend_q <= 1'b1;
    end else if (!i_an_complete) begin
        restart_pend_q <= 1'b0;
    end
end

// ------------------------------------------------------------
// Words sent to the negotiation submodule
// ------------------------------------------------------------
// duplex bits travel in the base page
assign o_adv_word = adv_q;
// null message pages come from software through this word
assign o_np_word  = x_mode ? {nptx_q[15:12], tog_q, nptx_q[10:0]} : nptx_q;
assign o_loc_pause = pause_dec(adv_q[`TAM_ADV_SYM], adv_q[`TAM_ADV_ASM], 1'b0);
assign o_loc_fault = adv_q[`TAM_ADV_RF_HI:`TAM_ADV_RF_LO];
assign o_lp_pause  = pause_dec(lpb_q[`TAM_ADV_SYM], lpb_q[`TAM_ADV_ASM], 1'b1);
// partner next page and fault code
assign o_lp_fault  = lpb_q[`TAM_ADV_RF_HI:`TAM_ADV_RF_LO];
assign o_lp_np     = lpb_q[`TAM_ADV_NP];
assign o_lp_half   = lpb_q[`TAM_ADV_HALF];
assign o_lp_full   = lpb_q[`TAM_ADV_FULL];

// ------------------------------------------------------------
// Read decode
// ------------------------------------------------------------
always @* begin
    rd_mux = 16'h0000;
    if (addr == `TAM_REG_CTRL) begin
        rd_mux[`TAM_CTRL_RST]  = rst_q;
        rd_mux[`TAM_CTRL_LOOP] = loop_q;
        rd_mux[`TAM_CTRL_ANEN] = an_en_q;
    end else if (addr == `TAM_REG_STAT) begin
        rd_mux[`TAM_STAT_EXT]     = 1'b1;
        rd_mux[`TAM_STAT_PRE_SUP] = 1'b1;
        rd_mux[`TAM_STAT_AN_ABLE] = 1'b1;
        rd_mux[`TAM_STAT_EXT_CAP] = 1'b1;
        // complete only when enabled and finished
        rd_mux[`TAM_STAT_AN_DONE] = an_en_q & i_an_complete & ~restart_pend_q;
        rd_mux[`TAM_STAT_RFAULT]  = i_remote_fault;
        rd_mux[`TAM_STAT_LINK]    = i_link_ok;
    end else if (addr == `TAM_REG_ADV) begin
        rd_mux = adv_q;
    end else if (addr == `TAM_REG_LPB) begin
        rd_mux = x_mode ? (lpb_q & `TAM_LPB_X_RMASK) : lpb_q;
    end else if (addr == `TAM_REG_EXP) begin
        rd_mux[`TAM_EXP_NP_ABLE] = 1'b1;
        rd_mux[`TAM_EXP_PAGE_RX] = page_rx_q;
    end else if (addr == `TAM_REG_NPTX) begin
        rd_mux = o_np_word;
    end else if (addr == `TAM_REG_LPNP) begin
        rd_mux = lpnp_q;
    end else begin
        // reserved and unmapped addresses read zero
        rd_mux = 16'h0000;
    end
end

// Sampled at the read strobe so a shifting answer cannot tear
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        rdata_q <= 16'h0000;
    end else if (rd_stb) begin
        rdata_q <= rd_mux;
    end
end

endmodule
